// ==== hdl/dual_uart_host_select.sv ====
/*
 * Two-channel asynchronous serial transceiver with its host bus front end:
 * chip select, channel pick, register select, per-channel line and modem
 * registers, character buffers, bit-rate generators, loopback and DMA
 * request outputs.
 * Assumes a host that holds select lines and data steady around its read
 * and write strobes for at least three clocks; all pins but CLOCK and NRST are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dual_uart_regs.svh"

module dual_uart_host_select
	import dual_uart_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
)
(
	input  wire logic       CLOCK,
	input  wire logic       NRST,
	input  wire logic       CHIP_SEL_N,
	input  wire logic       CHANNEL_PICK,
	input  wire logic       REG_SEL_BIT0,
	input  wire logic       REG_SEL_BIT1,
	input  wire logic       REG_SEL_BIT2,
	input  wire logic       READ_STROBE_N,
	input  wire logic       WRITE_STROBE_N,
	input  wire logic [7:0] DATA_IN,
	output      logic [7:0] DATA_OUT,
	output      logic       DATA_OE_N,
	input  wire logic       CARRIER_DETECT_N_CH_A,
	input  wire logic       CARRIER_DETECT_N_CH_B,
	input  wire logic       CLEAR_TO_SEND_N_CH_A,
	input  wire logic       CLEAR_TO_SEND_N_CH_B,
	input  wire logic       SERIAL_IN_A,
	input  wire logic       SERIAL_IN_B,
	output      logic       SERIAL_OUT_A,
	output      logic       SERIAL_OUT_B,
	output      logic       RX_DMA_REQUEST_A,
	output      logic       RX_DMA_REQUEST_B,
	output      logic       TX_DMA_REQUEST_A,
	output      logic       TX_DMA_REQUEST_B
);

	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	if (FIFO_DEPTH < 16 || (1 << (CW - 1)) != FIFO_DEPTH)
		$error("FIFO_DEPTH must be a power of two of at least 16");

	// ======================================================================
	// pin synchronisers: every pin but CLOCK and NRST passes two flops before use
	localparam int PW = 21;
	logic [PW-1:0] pin_raw;    // all asynchronous pins side by side
	logic [PW-1:0] pin_meta;   // first stage, read only by the second
	logic [PW-1:0] pin;        // second stage, safe to use

	assign pin_raw = {SERIAL_IN_B, SERIAL_IN_A, CLEAR_TO_SEND_N_CH_B,
		CLEAR_TO_SEND_N_CH_A, CARRIER_DETECT_N_CH_B, CARRIER_DETECT_N_CH_A,
		DATA_IN, WRITE_STROBE_N, READ_STROBE_N, REG_SEL_BIT2, REG_SEL_BIT1,
		REG_SEL_BIT0, CHANNEL_PICK, CHIP_SEL_N};

	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			pin_meta <= {2'h3, 4'hF, 8'h00, 7'h7F};
			pin      <= {2'h3, 4'hF, 8'h00, 7'h7F};
		end
		else
		begin
			pin_meta <= pin_raw;
			pin      <= pin_meta;
		end
	end

	logic       cs;          // chip selected
	logic       pick_a;      // channel pick high selects channel A
	logic [2:0] reg_sel;     // register index
	logic       rd_on;       // read strobe active under chip select
	logic       wr_on;       // write strobe active under chip select
	byte_t      wdata;       // host write data
	logic [1:0] cd_n;        // carrier detect, index 0 = A
	logic [1:0] cts_n;       // clear to send, index 0 = A
	logic [1:0] ser_in;      // serial inputs, index 0 = A

	assign cs      = !pin[0];
	assign pick_a  = pin[1];
	assign reg_sel = pin[4:2];
	assign rd_on   = cs && !pin[5];
	assign wr_on   = cs && !pin[6];
	assign wdata   = pin[14:7];
	assign cd_n    = pin[16:15];
	assign cts_n   = pin[18:17];
	assign ser_in  = pin[20:19];

	// ======================================================================
	// host access sequencing: a write acts once at strobe start, a read
	// holds its target from start to end so side effects land at the end
	logic       wr_prev;     // write strobe seen last cycle
	logic       rd_prev;     // read strobe seen last cycle
	logic       wr_go;       // one-cycle write pulse
	logic       rd_go;       // one-cycle read start pulse
	logic       rd_end;      // one-cycle read end pulse
	logic       rd_a;        // read targets channel A
	logic [2:0] rd_sel;      // read register index held for the read
	byte_t      alternate_function_reg;         // shared alternate function register
	logic       both;        // concurrent write to both channels

	assign wr_go  = wr_on && !wr_prev;
	assign rd_go  = rd_on && !rd_prev;
	assign rd_end = rd_prev && !rd_on;
	assign both   = alternate_function_reg[`AFR_BOTH_CH];

	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			wr_prev <= 1'b0;
			rd_prev <= 1'b0;
		end
		else
		begin
			wr_prev <= wr_on;
			rd_prev <= rd_on;
		end
	end

	// latch the read target when the strobe opens
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			rd_a   <= 1'b0;
			rd_sel <= 3'h0;
		end
		else if (rd_go)
		begin
			rd_a   <= pick_a;
			rd_sel <= reg_sel;
		end
	end

	// alternate function register is shared, so any write reaches it
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
			alternate_function_reg <= `AFR_RESET;
		else if (wr_go && reg_sel == `REG_ALT_FUNC)
			alternate_function_reg <= wdata;
	end

	byte_t      rd_val [2];  // per-channel read value, index 0 = A
	logic [1:0] ser_out;
	logic [1:0] rx_req;
	logic [1:0] tx_req;

	// ======================================================================
	// one channel per pass; index 0 is channel A, index 1 is channel B
	for (genvar g = 0; g < 2; g++)
	begin : chan
		logic        mine;       // channel pick addresses this channel
		logic        wr_here;    // write lands in this channel
		logic        rd_here;    // read ending here
		byte_t       lcr;        // line control
		byte_t       mcr;        // modem control
		logic [1:0]  trig;       // receive trigger select
		logic [15:0] div;        // bit-rate divisor
		logic [15:0] div_cnt;    // divisor counter
		logic        tick;       // sixteen per bit
		logic [3:0]  len;        // data bits, 5 to 8
		logic        par_en;
		logic        par_even;
		logic        loop;       // internal loopback
		logic        flush_rx;
		logic        flush_tx;

		assign mine     = (g == 0) ? pick_a : !pick_a;
		assign wr_here  = wr_go && (mine || both) && reg_sel != `REG_ALT_FUNC;
		assign rd_here  = rd_end && (rd_a == (g == 0));
		assign len      = 4'h5 + {2'h0, lcr[`LCR_LEN_HI:`LCR_LEN_LO]};
		assign par_en   = lcr[`LCR_PAR_EN];
		assign par_even = lcr[`LCR_PAR_EVEN];
		assign loop     = mcr[`MCR_LOOPBACK];
		assign flush_rx = wr_here && reg_sel == `REG_FIFO_CTRL && wdata[`FCR_RX_FLUSH];
		assign flush_tx = wr_here && reg_sel == `REG_FIFO_CTRL && wdata[`FCR_TX_FLUSH];

		// control registers; divisor reached with the access bit set
		always_ff @(posedge CLOCK)
		begin
			if (!NRST)
			begin
				lcr  <= `LCR_RESET;
				mcr  <= `MCR_RESET;
				trig <= `TRIG_RESET;
				div  <= `DIV_RESET;
			end
			else if (wr_here)
			begin
				unique case (reg_sel)
					`REG_DATA:       if (lcr[`LCR_DIV_ACCESS]) div[7:0] <= wdata;
					`REG_DIV_HI:     if (lcr[`LCR_DIV_ACCESS]) div[15:8] <= wdata;
					`REG_FIFO_CTRL:  trig <= wdata[`FCR_TRIG_HI:`FCR_TRIG_LO];
					`REG_LINE_CTRL:  lcr <= wdata;
					`REG_MODEM_CTRL: mcr <= wdata;
					default:         ;               // status is read only
				endcase
			end
		end

		// own rate generator; a zero divisor halts the channel
		always_ff @(posedge CLOCK)
		begin
			if (!NRST)
			begin
				div_cnt <= 16'h0000;
				tick    <= 1'b0;
			end
			else if (div_cnt + 16'h0001 >= div)
			begin
				div_cnt <= 16'h0000;
				tick    <= (div != 16'h0000);
			end
			else
			begin
				div_cnt <= div_cnt + 16'h0001;
				tick    <= 1'b0;
			end
		end

		// transmit buffer; a write to a full buffer is not taken
		logic          tx_in_ready;
		logic          tx_valid;
		logic          tx_take;
		byte_t         tx_byte;
		logic [CW-1:0] tx_count;
		tx_state_e     tx_state;
		logic [10:0]   tx_sr;      // start, data, parity, stop
		logic [3:0]    tx_left;    // bits still to send
		logic [3:0]    tx_ovs;     // sub-bit tick count
		logic          tx_line;

		assign tx_take = (tx_state == TX_IDLE) && tx_valid;

		byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo
		(
			.clk       (CLOCK),
			.nrst      (NRST),
			.flush     (flush_tx),
			.in_valid  (wr_here && reg_sel == `REG_DATA && !lcr[`LCR_DIV_ACCESS]),
			.in_ready  (tx_in_ready),
			.in_data   (wdata),
			.out_valid (tx_valid),
			.out_ready (tx_take),
			.out_data  (tx_byte),
			.count     (tx_count)
		);

		// frame builder: low start bit, data LSB first, parity, high stop
		function automatic logic [11:0] frame(input byte_t d, input logic [3:0] n,
			input logic pe, input logic ev);
			logic [11:0] f;
			logic        p;
			f = 12'hFFE;
			p = ev ? 1'b0 : 1'b1;
			for (int i = 0; i < 8; i++)
			begin
				if (i < n)
				begin
					f[i+1] = d[i];
					p      = p ^ d[i];
				end
			end
			if (pe)
				f[n+1] = p;
			return f;
		endfunction

		// transmitter: loads a whole frame and shifts it at the bit rate
		always_ff @(posedge CLOCK)
		begin
			if (!NRST)
			begin
				tx_state <= TX_IDLE;
				tx_sr    <= 11'h7FF;
				tx_left  <= 4'h0;
				tx_ovs   <= 4'h0;
			end
			else
			begin
				unique case (tx_state)
					TX_IDLE:
						if (tx_valid)
						begin
							tx_sr    <= 11'(frame(tx_byte, len, par_en, par_even));
							tx_left  <= len + 4'h2 + {3'h0, par_en};
							tx_ovs   <= 4'h0;
							tx_state <= TX_BUSY;
						end
					TX_BUSY:
						if (tick)
						begin
							tx_ovs <= tx_ovs + 4'h1;
							if (tx_ovs == `OVS_LAST)
							begin
								tx_sr   <= {1'b1, tx_sr[10:1]};
								tx_left <= tx_left - 4'h1;
								if (tx_left == 4'h1)
									tx_state <= TX_IDLE;
							end
						end
				endcase
			end
		end

		assign tx_line = (tx_state == TX_BUSY) ? tx_sr[0] : 1'b1;
		assign ser_out[g] = loop ? 1'b1 : tx_line;   // line idles in loopback
		assign tx_req[g]  = (tx_count == '0);

		// receiver: start found on a falling line, checked mid-bit
		logic                   rx_line;
		rx_state_e              rx_state;
		logic [3:0]             rx_ovs;
		logic [3:0]             rx_bit;
		logic [9:0]             rx_bits;
		logic                   rx_push;
		logic [`RX_ENTRY_W-1:0] rx_entry;  // {framing, parity, data}
		logic                   rx_in_ready;
		logic                   rx_valid;
		logic [`RX_ENTRY_W-1:0] rx_head;
		logic [CW-1:0]          rx_count;
		logic                   overrun;
		logic [3:0]             rx_last;   // index of the stop bit
		byte_t                  rx_data;
		logic                   rx_perr;

		assign rx_line = loop ? tx_line : ser_in[g];
		assign rx_last = len + {3'h0, par_en};
		assign rx_data = rx_bits[7:0] & ~(8'hFF << len);
		assign rx_perr = par_en && (rx_bits[len] != (^rx_data ^ !par_even));
		assign rx_push = (rx_state == RX_BITS) && tick && rx_ovs == `OVS_LAST
			&& rx_bit == rx_last;
		assign rx_entry = {!rx_line, rx_perr, rx_data};

		always_ff @(posedge CLOCK)
		begin
			if (!NRST)
			begin
				rx_state <= RX_IDLE;
				rx_ovs   <= 4'h0;
				rx_bit   <= 4'h0;
				rx_bits  <= 10'h000;
			end
			else
			begin
				unique case (rx_state)
					RX_IDLE:
						if (!rx_line)
						begin
							rx_ovs   <= 4'h0;
							rx_state <= RX_START;
						end
					RX_START:
						if (tick)
						begin
							rx_ovs <= rx_ovs + 4'h1;
							if (rx_ovs == `OVS_MID)  // glitch returns to idle
							begin
								rx_ovs   <= 4'h0;
								rx_bit   <= 4'h0;
								rx_state <= rx_line ? RX_IDLE : RX_BITS;
							end
						end
					RX_BITS:
						if (tick)
						begin
							rx_ovs <= rx_ovs + 4'h1;
							if (rx_ovs == `OVS_LAST)
							begin
								rx_bits[rx_bit] <= rx_line;
								rx_bit          <= rx_bit + 4'h1;
								if (rx_bit == rx_last)
									rx_state <= RX_IDLE;
							end
						end
					default:
						rx_state <= RX_IDLE;
				endcase
			end
		end

		// a host data read pops at the end of its strobe
		byte_fifo #(.WIDTH(`RX_ENTRY_W), .DEPTH(FIFO_DEPTH)) rx_fifo
		(
			.clk       (CLOCK),
			.nrst      (NRST),
			.flush     (flush_rx),
			.in_valid  (rx_push),
			.in_ready  (rx_in_ready),
			.in_data   (rx_entry),
			.out_valid (rx_valid),
			.out_ready (rd_here && rd_sel == `REG_DATA && !lcr[`LCR_DIV_ACCESS]),
			.out_data  (rx_head),
			.count     (rx_count)
		);

		// overrun: a character lost to a full buffer; set beats clear
		always_ff @(posedge CLOCK)
		begin
			if (!NRST)
				overrun <= 1'b0;
			else if (rx_push && !rx_in_ready)
				overrun <= 1'b1;
			else if (rd_here && rd_sel == `REG_LINE_STAT)
				overrun <= 1'b0;
		end

		// receive request once the chosen level is reached
		always_comb
		begin
			unique case (trig)
				2'h0: rx_req[g] = rx_count >= CW'(`TRIG_LEVEL0);
				2'h1: rx_req[g] = rx_count >= CW'(`TRIG_LEVEL1);
				2'h2: rx_req[g] = rx_count >= CW'(`TRIG_LEVEL2);
				2'h3: rx_req[g] = rx_count >= CW'(`TRIG_LEVEL3);
			endcase
		end

		// read value for the index the host holds now, so the first
		// driven cycle already carries the right register
		always_comb
		begin
			rd_val[g] = 8'h00;
			unique case (reg_sel)
				`REG_DATA:
					rd_val[g] = lcr[`LCR_DIV_ACCESS] ? div[7:0] : rx_head[7:0];
				`REG_DIV_HI:     rd_val[g] = lcr[`LCR_DIV_ACCESS] ? div[15:8] : 8'h00;
				`REG_FIFO_CTRL:  rd_val[g] = 8'(rx_count);
				`REG_LINE_CTRL:  rd_val[g] = lcr;
				`REG_MODEM_CTRL: rd_val[g] = mcr;
				`REG_LINE_STAT:
				begin
					rd_val[g][`LSR_RX_READY]  = rx_valid;
					rd_val[g][`LSR_OVERRUN]   = overrun;
					rd_val[g][`LSR_PAR_ERR]   = rx_valid && rx_head[8];
					rd_val[g][`LSR_FRAME_ERR] = rx_valid && rx_head[9];
					rd_val[g][`LSR_TX_EMPTY]  = tx_in_ready && tx_count == '0;
					rd_val[g][`LSR_TX_IDLE]   = tx_count == '0 && tx_state == TX_IDLE;
				end
				`REG_MODEM_STAT:
				begin
					rd_val[g][`MSR_CLEAR_SEND] = !cts_n[g];
					rd_val[g][`MSR_CARRIER]    = !cd_n[g];
				end
				`REG_ALT_FUNC:   rd_val[g] = alternate_function_reg;
			endcase
		end
	end

	// ======================================================================
	// read data register; bus released whenever no read is under way
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
			DATA_OUT <= 8'h00;
		else if (rd_on)
			DATA_OUT <= pick_a ? rd_val[0] : rd_val[1];
	end

	assign DATA_OE_N        = !(rd_on && rd_prev);
	assign SERIAL_OUT_A     = ser_out[0];
	assign SERIAL_OUT_B     = ser_out[1];
	assign RX_DMA_REQUEST_A = rx_req[0];
	assign RX_DMA_REQUEST_B = rx_req[1];
	assign TX_DMA_REQUEST_A = tx_req[0];
	assign TX_DMA_REQUEST_B = tx_req[1];

endmodule

`default_nettype wire

// ==== hdl/dual_uart_regs.svh ====
/*
 * Register indices, field positions, reset values and timing counts of the
 * two-channel serial front end. Definitions only; included by bare name.
 */
`ifndef DUAL_UART_REGS_SVH
`define DUAL_UART_REGS_SVH

// ==========================================================================
// register indices on the three select lines
`define REG_DATA       3'h0
`define REG_DIV_HI     3'h1
`define REG_FIFO_CTRL  3'h2
`define REG_LINE_CTRL  3'h3
`define REG_MODEM_CTRL 3'h4
`define REG_LINE_STAT  3'h5
`define REG_MODEM_STAT 3'h6
`define REG_ALT_FUNC   3'h7

// ==========================================================================
// field positions
`define LCR_LEN_LO     0
`define LCR_LEN_HI     1
`define LCR_PAR_EN     3
`define LCR_PAR_EVEN   4
`define LCR_DIV_ACCESS 7
`define FCR_RX_FLUSH   1
`define FCR_TX_FLUSH   2
`define FCR_TRIG_LO    6
`define FCR_TRIG_HI    7
`define MCR_LOOPBACK   4
`define LSR_RX_READY   0
`define LSR_OVERRUN    1
`define LSR_PAR_ERR    2
`define LSR_FRAME_ERR  3
`define LSR_TX_EMPTY   5
`define LSR_TX_IDLE    6
`define MSR_CLEAR_SEND 4
`define MSR_CARRIER    7
`define AFR_BOTH_CH    0

// ==========================================================================
// reset values
`define LCR_RESET      8'h03
`define MCR_RESET      8'h00
`define AFR_RESET      8'h00
`define DIV_RESET      16'h0001
`define TRIG_RESET     2'h0

// ==========================================================================
// receive trigger levels in entries, and oversampling points
`define TRIG_LEVEL0    8'h01
`define TRIG_LEVEL1    8'h04
`define TRIG_LEVEL2    8'h08
`define TRIG_LEVEL3    8'h0E
`define OVS_LAST       4'hF
`define OVS_MID        4'h7
`define RX_ENTRY_W     10

`endif

// ==== hdl/dual_uart_pkg.sv ====
/*
 * Types shared by the two-channel serial front end.
 * Assumes nothing of its surroundings.
 */
package dual_uart_pkg;

	// ======================================================================
	// state machine types and the byte type
	typedef enum logic [0:0] {TX_IDLE, TX_BUSY} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_e;
	typedef logic [7:0] byte_t;

endpackage

// ==== hdl/fifo_ram.sv ====
/*
 * Small dual-address memory for the character buffers: one write port,
 * one registered read port with write-first bypass.
 * Assumes a single clock shared with its user.
 */
`timescale 1ns/100ps
`default_nettype none

module fifo_ram
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input  wire logic                     clk,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output      logic [WIDTH-1:0]         rdata
);

	logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset needed

	// ======================================================================
	// write port
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// bypass so that a word written to an empty buffer is seen next cycle
	always_ff @(posedge clk)
	begin
		if (we && waddr == raddr)
			rdata <= wdata;
		else
			rdata <= mem[raddr];
	end

endmodule

`default_nettype wire

// ==== hdl/byte_fifo.sv ====
/*
 * First-in first-out buffer with valid/ready on both sides and a flush.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module byte_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     flush,
	input  wire logic                     in_valid,
	output      logic                     in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	output      logic                     out_valid,
	input  wire logic                     out_ready,
	output      logic [WIDTH-1:0]         out_data,
	output      logic [$clog2(DEPTH):0]   count
);

	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("byte_fifo depth must be a power of two");

	logic [AW:0] wp;       // write pointer with wrap bit
	logic [AW:0] rp;       // read pointer with wrap bit
	logic [AW:0] next_rp;  // read pointer after this cycle
	logic        push;
	logic        pop;

	assign count     = wp - rp;
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;
	assign next_rp   = flush ? '0 : (pop ? rp + 1'b1 : rp);

	// ======================================================================
	// pointers; flush empties without touching the memory
	always_ff @(posedge clk)
	begin
		if (!nrst || flush)
			wp <= '0;
		else if (push)
			wp <= wp + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			rp <= '0;
		else
			rp <= next_rp;
	end

	// read data leaves a register, addressed ahead by the next pointer
	fifo_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH)) ram
	(
		.clk   (clk),
		.we    (push),
		.waddr (wp[AW-1:0]),
		.wdata (in_data),
		.raddr (next_rp[AW-1:0]),
		.rdata (out_data)
	);

endmodule

`default_nettype wire

// ==== testbench/dual_uart_host_select_assertions.sv ====
/*
 * Port-level checker for the two-channel serial front end.
 * Assumes the host holds strobes low for several clocks per access.
 */
`timescale 1ns/100ps
`default_nettype none

module host_select_checker
(
	input wire logic       CLOCK,
	input wire logic       NRST,
	input wire logic       CHIP_SEL_N,
	input wire logic       READ_STROBE_N,
	input wire logic       WRITE_STROBE_N,
	input wire logic       DATA_OE_N,
	input wire logic       RX_DMA_REQUEST_A,
	input wire logic       RX_DMA_REQUEST_B,
	input wire logic       TX_DMA_REQUEST_A,
	input wire logic       TX_DMA_REQUEST_B
);
	// ======================================================================
	// one clock domain, so clocking and disable are shared
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	// bus released once the read strobe has been high a while
	bus_idle_a: assert property (READ_STROBE_N [*5] |-> DATA_OE_N)
		else $error("data bus driven without a read");
	// device deselected for five clocks never drives
	cs_idle_a: assert property (CHIP_SEL_N [*5] |-> DATA_OE_N)
		else $error("data bus driven while deselected");
	// a selected read is answered within the sync delay
	read_answer_a: assert property ($fell(READ_STROBE_N) && !CHIP_SEL_N
		##1 (!READ_STROBE_N && !CHIP_SEL_N) [*5] |-> ##[0:1] !DATA_OE_N)
		else $error("read not answered in time");
	// driver stays on while the read is still under way
	read_hold_a: assert property (!DATA_OE_N && !READ_STROBE_N && !CHIP_SEL_N
		|=> !DATA_OE_N)
		else $error("driver dropped during a read");
	// driver only turns on in reply to a selected read
	read_cause_a: assert property ($fell(DATA_OE_N)
		|-> !$past(READ_STROBE_N, 2) && !$past(CHIP_SEL_N, 2))
		else $error("driver on without a selected read");
	// request levels out of reset
	reset_dma_a: assert property ($rose(NRST) |-> TX_DMA_REQUEST_A
		&& TX_DMA_REQUEST_B && !RX_DMA_REQUEST_A && !RX_DMA_REQUEST_B)
		else $error("request levels wrong after reset");
	// transmit buffer only leaves empty through a selected write
	tx_fill_a: assert property ($fell(TX_DMA_REQUEST_A)
		|-> !$past(WRITE_STROBE_N, 2) && !$past(CHIP_SEL_N, 2))
		else $error("channel A transmit buffer filled without a write");
	tx_b_fill_a: assert property ($fell(TX_DMA_REQUEST_B)
		|-> !$past(WRITE_STROBE_N, 2) && !$past(CHIP_SEL_N, 2))
		else $error("channel B transmit buffer filled without a write");
endmodule

bind dual_uart_host_select host_select_checker u_host_select_checker
(
	.CLOCK(CLOCK), .NRST(NRST), .CHIP_SEL_N(CHIP_SEL_N), .READ_STROBE_N(READ_STROBE_N),
	.WRITE_STROBE_N(WRITE_STROBE_N), .DATA_OE_N(DATA_OE_N),
	.RX_DMA_REQUEST_A(RX_DMA_REQUEST_A), .RX_DMA_REQUEST_B(RX_DMA_REQUEST_B),
	.TX_DMA_REQUEST_A(TX_DMA_REQUEST_A), .TX_DMA_REQUEST_B(TX_DMA_REQUEST_B)
);

`default_nettype wire

// ==== testbench/host_cpu_model.sv ====
/*
 * Host processor on the 8-bit parallel bus: one task per access.
 * Assumes the device clock; signals change by non-blocking assignment.
 */
`timescale 1ns/100ps
`default_nettype none

module host_cpu_model
(
	input  wire logic       clk,
	input  wire logic [7:0] rd_data,
	output var  logic       cs_n,
	output var  logic       pick,
	output var  logic [2:0] idx,
	output var  logic       rd_n,
	output var  logic       wr_n,
	output var  logic [7:0] wdata
);
	// ======================================================================
	// idle bus at time zero
	initial
	begin
		cs_n = 1'b1;
		pick = 1'b0;
		idx = 3'h0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		wdata = 8'h00;
	end

	// ======================================================================
	// one access: strobe low six clocks, high six clocks after
	task automatic xfer(input logic cs, input logic ch, input logic [2:0] r,
		input logic wr, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		cs_n <= cs;
		pick <= ch;
		idx <= r;
		wdata <= d;
		rd_n <= wr;
		wr_n <= !wr;
		// long enough to cover the two-flop sync plus answer
		repeat (6) @(posedge clk);
		q = rd_data;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		// a released bus shows no stale value
		wdata <= ~d;
		repeat (6) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// ==== testbench/dual_uart_host_select_tb.sv ====
/*
 * Self-checking bench for the two-channel serial front end.
 * Assumes the host model drives the bus; serial inputs stay idle high.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dual_uart_regs.svh"

module dual_uart_host_select_tb;
	logic       clk = 1'b0; // 20 MHz bench clock
	logic       nrst = 1'b0; // synchronous active-low reset
	logic       cs_n, pick, rd_n, wr_n; // host bus controls
	logic [2:0] idx; // register index
	logic [7:0] wdata, rdata; // bus data both ways
	logic       oe_n, sout_a, sout_b, rxr_a, rxr_b, txr_a, txr_b; // outputs
	logic       cts_a = 1'b0, cd_a = 1'b1, cts_b = 1'b1, cd_b = 1'b0; // modem pins
	logic [7:0] q; // read result
	int         miscompares = 0; // mismatches
	int         checked = 0; // comparisons

	always #25 clk = ~clk;

	// ======================================================================
	// design and host
	dual_uart_host_select u_dual_uart_host_select (.CLOCK(clk), .NRST(nrst),
		.CHIP_SEL_N(cs_n), .CHANNEL_PICK(pick), .REG_SEL_BIT0(idx[0]),
		.REG_SEL_BIT1(idx[1]), .REG_SEL_BIT2(idx[2]), .READ_STROBE_N(rd_n),
		.WRITE_STROBE_N(wr_n), .DATA_IN(wdata), .DATA_OUT(rdata), .DATA_OE_N(oe_n),
		.CARRIER_DETECT_N_CH_A(cd_a), .CARRIER_DETECT_N_CH_B(cd_b),
		.CLEAR_TO_SEND_N_CH_A(cts_a), .CLEAR_TO_SEND_N_CH_B(cts_b),
		.SERIAL_IN_A(1'b1), .SERIAL_IN_B(1'b1), .SERIAL_OUT_A(sout_a),
		.SERIAL_OUT_B(sout_b), .RX_DMA_REQUEST_A(rxr_a), .RX_DMA_REQUEST_B(rxr_b),
		.TX_DMA_REQUEST_A(txr_a), .TX_DMA_REQUEST_B(txr_b));
	host_cpu_model u_host_cpu_model (.clk(clk), .rd_data(rdata), .cs_n(cs_n),
		.pick(pick), .idx(idx), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata));

	// ======================================================================
	// comparison, verdict and access shorthands
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic ch, input logic [2:0] r, input logic [7:0] d);
		u_host_cpu_model.xfer(1'b0, ch, r, 1'b1, d, q);
	endtask

	task automatic rd(input logic ch, input logic [2:0] r);
		u_host_cpu_model.xfer(1'b0, ch, r, 1'b0, 8'h00, q);
	endtask

	// ======================================================================
	// hang guard, far above the few hundred clocks the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	// ======================================================================
	// tests
	initial
	begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(1'b1, `REG_LINE_CTRL);
		chk("lcr a reset", q, `LCR_RESET);
		rd(1'b1, `REG_MODEM_STAT);
		chk("msr a", q & 8'h90, 8'h10);
		rd(1'b0, `REG_MODEM_STAT);
		chk("msr b", q & 8'h90, 8'h80);
		// different values per channel prove the pick polarity
		wr(1'b1, `REG_LINE_CTRL, 8'h1B);
		wr(1'b0, `REG_LINE_CTRL, 8'h0A);
		rd(1'b1, `REG_LINE_CTRL);
		chk("lcr a", q & 8'h9B, 8'h1B);
		rd(1'b0, `REG_LINE_CTRL);
		chk("lcr b", q & 8'h9B, 8'h0A);
		// a strobe with chip select high must be ignored
		u_host_cpu_model.xfer(1'b1, 1'b1, `REG_LINE_CTRL, 1'b1, 8'h00, q);
		rd(1'b1, `REG_LINE_CTRL);
		chk("lcr a deselected", q & 8'h9B, 8'h1B);
		// concurrent write reaches both channels despite the pick
		wr(1'b0, `REG_ALT_FUNC, 8'h01);
		wr(1'b0, `REG_LINE_CTRL, 8'h1A);
		wr(1'b0, `REG_ALT_FUNC, 8'h00);
		rd(1'b1, `REG_LINE_CTRL);
		chk("lcr a both", q & 8'h9B, 8'h1A);
		rd(1'b0, `REG_LINE_CTRL);
		chk("lcr b both", q & 8'h9B, 8'h1A);
		// seven-bit even-parity character looped back on channel A
		wr(1'b1, `REG_MODEM_CTRL, 8'h10);
		wr(1'b1, `REG_DATA, 8'h5A);
		repeat (400) @(posedge clk);
		chk("line a held", {7'h00, sout_a}, 8'h01);
		chk("rx request a", {7'h00, rxr_a}, 8'h01);
		chk("rx request b", {7'h00, rxr_b}, 8'h00);
		rd(1'b1, `REG_LINE_STAT);
		chk("lsr a", q & 8'h6F, 8'h61);
		rd(1'b1, `REG_DATA);
		chk("rx data a", q, 8'h5A);
		chk("rx request a drained", {7'h00, rxr_a}, 8'h00);
		chk("tx request a", {7'h00, txr_a}, 8'h01);
		chk("line b idle", {7'h00, sout_b}, 8'h01);
		print_verdict();
	end
endmodule

`default_nettype wire
